// File: verilog/charger_option_defines.vh
// Constants for the charger option control word
// Behaviour
// - Bits 12:11 pick depletion fraction, reset 11
// - Calibration below threshold: battery off, adapter on
// - Depletion comparator clears after rising hysteresis or at zero charge voltage
// - Zero charge voltage disables depletion protection
// - Bit 10 lowers or raises frequency 18%
// - Bit 9 enables frequency shift, reset 0
// - Bit 8 disables or sets high-side short threshold
// - Bit 7 picks low-side short threshold
// - Writing bit 6 high starts calibration cycle
// - Calibration end clears bit 6 by itself
// - Writing bit 6 low stops calibration
// - Bit 5 selects current monitor amplifier
// - Bit 4 reads adapter presence, read-only
// - Bit 1 enables adapter overcurrent trip
// - Bit 0 inhibits charging
// - Word read and word write only, 16 bits
// - Command code 0x12 selects the option word
`ifndef CHARGER_OPTION_DEFINES_VH
`define CHARGER_OPTION_DEFINES_VH

`define CMD_OPTION_WORD      8'h12
`define OPTION_WIDTH         16
`define OPTION_RESET         13'h1902
`define OPTION_WRITE_MASK    13'h1fef
`define BIT_DEPL_HI          12
`define BIT_DEPL_LO          11
`define BIT_FREQ_DIR         10
`define BIT_FREQ_EN          9
`define BIT_HS_SHORT         8
`define BIT_LS_SHORT         7
`define BIT_CAL_EN           6
`define BIT_MON_SEL          5
`define BIT_ADAPTER          4
`define BIT_ADAPTER_OVERCURRENT_TRIP             1
`define BIT_INHIBIT          0

`endif

// File: verilog/option_word_store.v
// Storage for the writable bits of the option word
`timescale 1ns/1ps
`default_nettype none
`include "charger_option_defines.vh"

module option_word_store
(
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        wr_i,
  input  wire [12:0] wr_data_i,
  input  wire        cal_clear_i,
  output reg  [12:0] word_o
);

  // ****************************************
  // Register
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      word_o <= `OPTION_RESET;
    else if (wr_i)
      word_o <= wr_data_i & `OPTION_WRITE_MASK;
    else if (cal_clear_i)
      word_o[`BIT_CAL_EN] <= 1'b0;
  end

endmodule
`default_nettype wire

// File: verilog/charger_option_control.v
// Charger option control word: host access and learn-cycle switch control
`timescale 1ns/1ps
`default_nettype none
`include "charger_option_defines.vh"

module charger_option_control
(
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        cmd_valid_i,
  input  wire [7:0]  cmd_code_i,
  input  wire        cmd_write_i,
  input  wire [15:0] cmd_wdata_i,
  input  wire        adapter_detect_input_i,
  input  wire        depl_below_i,
  input  wire        depl_above_hyst_i,
  input  wire        charge_voltage_zero_i,
  output reg  [15:0] rdata_o,
  output reg         rdata_valid_o,
  output reg  [1:0]  depl_sel_o,
  output reg         freq_up_o,
  output reg         freq_adjust_en_o,
  output reg         high_side_short_threshold_o,
  output reg         low_side_short_threshold_o,
  output reg         current_monitor_output_o,
  output reg         adapter_overcurrent_trip_o,
  output reg         charge_inhibit_o,
  output reg         adapter_switch_o,
  output reg         battery_switch_o
);

  wire [12:0] word;
  wire        sel;
  wire        wr;
  wire        cal_clear;
  wire        cal_on;
  reg         depleted_reg;
  reg         adapter_reg;
  wire [15:0] full_word;
  localparam [12:0] RESET_WORD = `OPTION_RESET;

  // ****************************************
  // Host access
  // ****************************************
  assign sel = cmd_valid_i && (cmd_code_i == `CMD_OPTION_WORD);
  assign wr  = sel && cmd_write_i;
  assign cal_on = word[`BIT_CAL_EN];
  assign cal_clear = cal_on && depleted_reg && !wr;
  assign full_word = {3'h0, word[12:5], adapter_reg, word[3:0]};

  option_word_store u_store
  (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .wr_i        (wr),
    .wr_data_i   (cmd_wdata_i[12:0]),
    .cal_clear_i (cal_clear),
    .word_o      (word)
  );

  // ****************************************
  // Depletion comparator with hysteresis
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      depleted_reg <= 1'b0;
    else if (charge_voltage_zero_i)
      depleted_reg <= 1'b0;
    else if (depl_below_i)
      depleted_reg <= 1'b1;
    else if (depl_above_hyst_i)
      depleted_reg <= 1'b0;
  end

  // ****************************************
  // Adapter presence sample
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      adapter_reg <= 1'b0;
    else
      adapter_reg <= adapter_detect_input_i;
  end

  // ****************************************
  // Read path
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_valid_o <= 1'b0;
    else
      rdata_valid_o <= sel && !cmd_write_i;
  end

  // Read word holds until the next read
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 16'h0000;
    else if (sel && !cmd_write_i)
      rdata_o <= full_word;
  end

  // ****************************************
  // Depletion threshold select
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      depl_sel_o <= RESET_WORD[`BIT_DEPL_HI:`BIT_DEPL_LO];
    else
      depl_sel_o <= word[`BIT_DEPL_HI:`BIT_DEPL_LO];
  end

  // ****************************************
  // Frequency direction
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      freq_up_o <= RESET_WORD[`BIT_FREQ_DIR];
    else
      freq_up_o <= word[`BIT_FREQ_DIR];
  end

  // ****************************************
  // Frequency adjust enable
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      freq_adjust_en_o <= RESET_WORD[`BIT_FREQ_EN];
    else
      freq_adjust_en_o <= word[`BIT_FREQ_EN];
  end

  // ****************************************
  // High-side short threshold
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      high_side_short_threshold_o <= RESET_WORD[`BIT_HS_SHORT];
    else
      high_side_short_threshold_o <= word[`BIT_HS_SHORT];
  end

  // ****************************************
  // Low-side short threshold
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      low_side_short_threshold_o <= RESET_WORD[`BIT_LS_SHORT];
    else
      low_side_short_threshold_o <= word[`BIT_LS_SHORT];
  end

  // ****************************************
  // Current monitor select
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      current_monitor_output_o <= RESET_WORD[`BIT_MON_SEL];
    else
      current_monitor_output_o <= word[`BIT_MON_SEL];
  end

  // ****************************************
  // Adapter overcurrent trip enable
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      adapter_overcurrent_trip_o <= RESET_WORD[`BIT_ADAPTER_OVERCURRENT_TRIP];
    else
      adapter_overcurrent_trip_o <= word[`BIT_ADAPTER_OVERCURRENT_TRIP];
  end

  // ****************************************
  // Charge inhibit
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      charge_inhibit_o <= RESET_WORD[`BIT_INHIBIT];
    else
      charge_inhibit_o <= word[`BIT_INHIBIT];
  end

  // ****************************************
  // Learn cycle switches
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      adapter_switch_o <= 1'b1;
      battery_switch_o <= 1'b0;
    end
    else if (cal_on && !depleted_reg)
    begin
      // Learn cycle runs on battery until depleted or stopped
      adapter_switch_o <= 1'b0;
      battery_switch_o <= 1'b1;
    end
    else
    begin
      // Depleted or stopped: the adapter carries the load again
      adapter_switch_o <= 1'b1;
      battery_switch_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: testbench/host_model.sv
// Host side that issues word transactions to the option word
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire         clk_sys_i,
  output logic        cmd_valid_o = 1'b0,
  output logic        cmd_write_o = 1'b0,
  output logic [7:0]  cmd_code_o = 8'h00,
  output logic [15:0] cmd_wdata_o = 16'h0000
);
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o} = {1'b1, w, c, d};
    @(posedge clk_sys_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// File: testbench/option_checker_asserts.sv
// Checker for the option word ports
`timescale 1ns/1ps
`default_nettype none
module option_checker (
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_write_i,
  input wire logic        depl_below_i,
  input wire logic        depl_above_hyst_i,
  input wire logic        charge_voltage_zero_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rdata_valid_o,
  input wire logic        freq_up_o,
  input wire logic        charge_inhibit_o,
  input wire logic        adapter_switch_o,
  input wire logic        battery_switch_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire rq = cmd_valid_i && cmd_code_i == 8'h12;
  a_read_answer: assert property (rq && !cmd_write_i |=> rdata_valid_o) else $error("no read answer");
  a_no_spurious: assert property (!(rq && !cmd_write_i) |=> !rdata_valid_o) else $error("bad answer");
  a_read_top: assert property (rdata_valid_o |-> rdata_o[15:13] == 3'h0) else $error("top bits set");
  a_inhibit_follow: assert property (rq && cmd_write_i |-> ##2 charge_inhibit_o == $past(cmd_wdata_i[0], 2))
    else $error("inhibit wrong");
  a_freq_follow: assert property (rq && cmd_write_i |-> ##2 freq_up_o == $past(cmd_wdata_i[10], 2))
    else $error("freq dir wrong");
  a_learn_start: assert property ((rq && cmd_write_i && cmd_wdata_i[6] && !depl_below_i
    && (depl_above_hyst_i || charge_voltage_zero_i))
    ##1 (!depl_below_i && !cmd_valid_i) |=> battery_switch_o && !adapter_switch_o)
    else $error("learn not started");
  a_learn_stop: assert property (rq && cmd_write_i && !cmd_wdata_i[6] |-> ##2 adapter_switch_o)
    else $error("learn not stopped");
  a_deplete_end: assert property (battery_switch_o && depl_below_i && !cmd_valid_i && !charge_voltage_zero_i
    |-> ##2 adapter_switch_o && !battery_switch_o) else $error("depletion ignored");
  c_write: cover property (rq && cmd_write_i);
  c_learn: cover property (battery_switch_o);
  c_end: cover property ($fell(battery_switch_o));
endmodule
bind charger_option_control option_checker chk_i (.*);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the charger option word
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 0, nrst_i = 0, adp = 0, below = 0, hyst = 0, vzero = 0;
  logic cv, cw, rv, fu, fe, hs, ls, mon, oc, inh, asw, bsw;
  logic [7:0] cc;
  logic [15:0] cd, rdata;
  logic [1:0] dsel;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  wire [10:0] outs = {dsel, fu, fe, hs, ls, mon, oc, inh, asw, bsw};
  always #2.5 clk_sys_i = ~clk_sys_i;
  host_model host (.clk_sys_i(clk_sys_i), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_code_o(cc),
    .cmd_wdata_o(cd));
  charger_option_control dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(cv),
    .cmd_code_i(cc), .cmd_write_i(cw), .cmd_wdata_i(cd), .adapter_detect_input_i(adp),
    .depl_below_i(below), .depl_above_hyst_i(hyst), .charge_voltage_zero_i(vzero), .rdata_o(rdata),
    .rdata_valid_o(rv), .depl_sel_o(dsel), .freq_up_o(fu), .freq_adjust_en_o(fe),
    .high_side_short_threshold_o(hs), .low_side_short_threshold_o(ls), .current_monitor_output_o(mon),
    .adapter_overcurrent_trip_o(oc), .charge_inhibit_o(inh), .adapter_switch_o(asw), .battery_switch_o(bsw));
  task chk(input logic [16:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(input logic [15:0] e); host.xfer(0, 8'h12, 16'h0); chk({rv, rdata}, {1'b1, e}); endtask
  task wr(input logic [15:0] d); host.xfer(1, 8'h12, d); @(posedge clk_sys_i); #1; endtask
  task step(input int n); repeat (n) @(posedge clk_sys_i); #1; endtask
  task t_fields;
    rd(16'h1902); chk(outs, 11'h64a);
    wr(16'hffbf); chk(outs, 11'h7fe); rd(16'h1faf);
    adp = 1; wr(16'h0000); chk(outs, 11'h002); rd(16'h0010);
    for (int i = 0; i < 4; i++) begin wr({3'h0, i[1:0], 11'h0}); chk(outs, {i[1:0], 9'h002}); end
    host.xfer(1, 8'h14, 16'hffff); host.xfer(0, 8'h13, 0); chk(rv, 0); rd(16'h1810);
    $display("TB: field test done");
  endtask
  task t_learn;
    wr(16'h0040); chk({asw, bsw}, 2'b01);
    below = 1; step(2); chk({asw, bsw}, 2'b10); rd(16'h0010);
    below = 0; wr(16'h0040); chk({asw, bsw}, 2'b10); rd(16'h0010);
    hyst = 1; wr(16'h0040); hyst = 0; chk({asw, bsw}, 2'b01);
    wr(16'h0000); chk({asw, bsw}, 2'b10);
    vzero = 1; wr(16'h0040); below = 1; step(3); chk({asw, bsw}, 2'b01);
    below = 0; vzero = 0; wr(16'h0000); chk({asw, bsw}, 2'b10);
    $display("TB: learn test done");
  endtask
  task conclude;
    $display("TB: counts bad=%0d checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_i) if (++cycles == 3000) begin bad_count++; conclude; end
  initial
  begin
    step(10);
    nrst_i = 1;
    t_fields;
    t_learn;
    conclude;
  end
endmodule
`default_nettype wire
